// ### hw/prbs_params.svh
// Register offsets, field positions, limits and response codes of the PRBS self-test block
`ifndef PRBS_PARAMS_SVH
`define PRBS_PARAMS_SVH
`define PRBS_OFS_GEN_CTRL   8'h00
`define PRBS_OFS_USER_WORD  8'h04
`define PRBS_OFS_CHK_CTRL   8'h08
`define PRBS_OFS_CHK_STAT   8'h0C
`define PRBS_OFS_BIT_CNT    8'h10
`define PRBS_OFS_ERR_CNT    8'h14
`define PRBS_OFS_TAP_PRE    8'h18
`define PRBS_OFS_TAP_MAIN   8'h1C
`define PRBS_OFS_TAP_POST   8'h20
`define PRBS_OFS_IRQ_STAT   8'h24
`define PRBS_OFS_IRQ_EN     8'h28
`define PRBS_OFS_IRQ_CLR    8'h2C
// Generator control fields
`define PRBS_GEN_EN_BIT     0
`define PRBS_GEN_PRBS_BIT   1
`define PRBS_GEN_DCBAL_BIT  2
`define PRBS_SEL_LSB        4
// Checker control fields
`define PRBS_CHK_EN_BIT     0
`define PRBS_CHK_AUTO_BIT   1
`define PRBS_CHK_INV_BIT    2
`define PRBS_CHK_FRZ_BIT    3
`define PRBS_CHK_CLR_BIT    7
// Checker status fields
`define PRBS_STAT_LOCK_BIT  0
`define PRBS_STAT_INV_BIT   1
`define PRBS_STAT_SEL_LSB   4
// Interrupt bits
`define PRBS_IRQ_ERR_BIT    0
`define PRBS_IRQ_LOCK_BIT   1
`define PRBS_IRQ_LOSS_BIT   2
// Tap sign bit within a 7-bit tap field
`define PRBS_TAP_SIGN_BIT   6
`define PRBS_ERR_MAX        11'h7FF
`define PRBS_LOCK_GOOD      4'hF
`define PRBS_SLIP_LIMIT     4'h8
`define PRBS_RESP_OKAY      2'h0
`define PRBS_RESP_SLVERR    2'h2
`endif

// ### hw/prbs_pkg.sv
// Types shared by the PRBS self-test block
package prbs_pkg;
	typedef enum logic [2:0] {
		PRBS_P7, PRBS_P9, PRBS_P11, PRBS_P15,
		PRBS_P23, PRBS_P31, PRBS_P58, PRBS_P63
	} prbs_poly_t;
	typedef enum logic [1:0] {
		PRBS_HUNT, PRBS_SEED, PRBS_TRACK
	} prbs_chk_state_t;
endpackage

// ### hw/prbs_lane.sv
// PRBS pattern generator, checker, counters and AXI4-Lite registers
// Behaviour
// - Generator sends repeating 16-bit user word or a PRBS sequence.
// - DC balance sends the complement of the user word every other time.
// - Eight PRBS orders 7,9,11,15,23,31,58,63, period two power minus one.
// - Checker uses software sequence and polarity, or detects both itself.
// - Checker recognises exactly the generator's set of sequences.
// - Detected errors accumulate in an 11-bit error counter.
// - Compare 32-bit words, one count per mismatching bit.
// - A bit counter records checked bits; both counters are readable.
// - Counter values are guaranteed only while frozen.
// - Leaving freeze resumes counting from the held values.
`include "prbs_params.svh"
module prbs_lane #(
	parameter int BIT_W = 32
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      tx_word,
	output logic             tx_valid,
	input  wire logic [31:0] rx_word,
	input  wire logic        rx_valid,
	output logic [6:0]       tap_pre,
	output logic [6:0]       tap_main,
	output logic [6:0]       tap_post,
	output logic             irq
);
	// Next state of a Fibonacci LFSR (x^n + x^k + 1) for one poly
	function automatic logic [63:0] lfsr_step(
		input logic [63:0] s, input logic [2:0] p);
		logic fb;
		fb = 1'b0;
		case (p)
			3'h0: fb = s[6] ^ s[5];
			3'h1: fb = s[8] ^ s[4];
			3'h2: fb = s[10] ^ s[8];
			3'h3: fb = s[14] ^ s[13];
			3'h4: fb = s[22] ^ s[17];
			3'h5: fb = s[30] ^ s[27];
			3'h6: fb = s[57] ^ s[38];
			default: fb = s[62] ^ s[61];
		endcase
		return {s[62:0], fb};
	endfunction
	// Advance 32 bits; returns new state, output bits in s[31:0]
	function automatic logic [63:0] lfsr_adv32(
		input logic [63:0] s, input logic [2:0] p);
		logic [63:0] t;
		t = s;
		for (int i = 0; i < 32; i++)
			t = lfsr_step(t, p);
		return t;
	endfunction
	// Count of ones in a 32-bit word
	function automatic logic [5:0] ones32(input logic [31:0] v);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 0; i < 32; i++)
			c = c + {5'h00, v[i]};
		return c;
	endfunction

	// Registers
	logic [7:0]  gen_ctrl_r;
	logic [15:0] user_word_r;
	logic [7:0]  chk_ctrl_r;
	logic [6:0]  tap_pre_r;
	logic [6:0]  tap_main_r;
	logic [6:0]  tap_post_r;
	logic [2:0]  irq_stat_r;
	logic [2:0]  irq_en_r;
	logic [7:0]  aw_addr_r;
	logic        aw_have_r;
	logic [31:0] w_data_r;
	logic        w_have_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	// Write channel acceptance: each held until the response drains
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready  = !w_have_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	wire        aw_take = s_axi_awvalid && s_axi_awready;
	wire        w_take  = s_axi_wvalid && s_axi_wready;
	wire        wr_go   = aw_have_r && w_have_r && !bvalid_r;
	wire        ar_take = s_axi_arvalid && s_axi_arready;
	wire [7:0]  wa      = aw_addr_r;
	wire [31:0] wd      = w_data_r;
	wire wr_gen   = wr_go && wa == `PRBS_OFS_GEN_CTRL;
	wire wr_user  = wr_go && wa == `PRBS_OFS_USER_WORD;
	wire wr_chk   = wr_go && wa == `PRBS_OFS_CHK_CTRL;
	wire wr_pre   = wr_go && wa == `PRBS_OFS_TAP_PRE;
	wire wr_main  = wr_go && wa == `PRBS_OFS_TAP_MAIN;
	wire wr_post  = wr_go && wa == `PRBS_OFS_TAP_POST;
	wire wr_ien   = wr_go && wa == `PRBS_OFS_IRQ_EN;
	wire wr_iclr  = wr_go && wa == `PRBS_OFS_IRQ_CLR;
	wire wr_ok    = wr_gen | wr_user | wr_chk | wr_pre | wr_main |
		wr_post | wr_ien | wr_iclr;

	// AXI write path; byte 0 carries every writable field except user word bits 15:8, in byte 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			bvalid_r  <= 1'b0;
			bresp_r   <= `PRBS_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_ok ? `PRBS_RESP_OKAY : `PRBS_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Write strobes: byte lanes gate each field
	logic lane0_r;
	logic lane1_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lane0_r <= 1'b0;
			lane1_r <= 1'b0;
		end else if (w_take) begin
			lane0_r <= s_axi_wstrb[0];
			lane1_r <= s_axi_wstrb[1];
		end
	end

	// Control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gen_ctrl_r  <= 8'h00;
			user_word_r <= 16'h0000;
			chk_ctrl_r  <= 8'h00;
			tap_pre_r   <= 7'h00;
			tap_main_r  <= 7'h00;
			tap_post_r  <= 7'h00;
			irq_en_r    <= 3'h0;
		end else begin
			if (wr_gen && lane0_r)
				gen_ctrl_r <= wd[7:0];
			if (wr_user && lane0_r)
				user_word_r[7:0] <= wd[7:0];
			if (wr_user && lane1_r)
				user_word_r[15:8] <= wd[15:8];
			if (wr_chk && lane0_r)
				chk_ctrl_r <= wd[7:0];
			if (wr_pre && lane0_r)
				tap_pre_r <= wd[6:0];
			if (wr_main && lane0_r)
				tap_main_r <= wd[6:0];
			if (wr_post && lane0_r)
				tap_post_r <= wd[6:0];
			if (wr_ien && lane0_r)
				irq_en_r <= wd[2:0];
		end
	end
	assign tap_pre  = tap_pre_r;
	assign tap_main = tap_main_r;
	assign tap_post = tap_post_r;

	// Generator control decode
	wire       gen_en    = gen_ctrl_r[`PRBS_GEN_EN_BIT];
	wire       gen_prbs  = gen_ctrl_r[`PRBS_GEN_PRBS_BIT];
	wire       gen_dcbal = gen_ctrl_r[`PRBS_GEN_DCBAL_BIT];
	wire [2:0] gen_sel   = gen_ctrl_r[`PRBS_SEL_LSB +: 3];

	// Generator: 32-bit word is two 16-bit symbols, first in high half
	logic [63:0] gen_lfsr_r;
	logic [31:0] tx_word_r;
	logic        tx_valid_r;
	wire  [63:0] gen_next = lfsr_adv32(gen_lfsr_r, gen_sel);
	wire  [15:0] sym_b = gen_dcbal ? ~user_word_r : user_word_r;
	wire  [31:0] user_pair = {user_word_r, sym_b};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gen_lfsr_r <= 64'hFFFF_FFFF_FFFF_FFFF;
			tx_word_r  <= 32'h0000_0000;
			tx_valid_r <= 1'b0;
		end else begin
			tx_valid_r <= gen_en;
			if (gen_en && gen_prbs) begin
				gen_lfsr_r <= gen_next;
				tx_word_r  <= gen_next[31:0];
			end else if (gen_en) begin
				tx_word_r <= user_pair;
			end
		end
	end
	assign tx_word  = tx_word_r;
	assign tx_valid = tx_valid_r;

	// Checker control decode
	wire       chk_en   = chk_ctrl_r[`PRBS_CHK_EN_BIT];
	wire       chk_auto = chk_ctrl_r[`PRBS_CHK_AUTO_BIT];
	wire       chk_inv  = chk_ctrl_r[`PRBS_CHK_INV_BIT];
	wire       chk_frz  = chk_ctrl_r[`PRBS_CHK_FRZ_BIT];
	wire       cnt_clr  = wr_chk && lane0_r && wd[`PRBS_CHK_CLR_BIT];
	wire [2:0] man_sel  = chk_ctrl_r[`PRBS_SEL_LSB +: 3];

	// Checker: seeded from the received stream, then self-predicting
	prbs_pkg::prbs_chk_state_t st_r;
	logic [63:0] chk_lfsr_r;
	logic [2:0]  cur_sel_r;
	logic        cur_inv_r;
	logic [3:0]  good_r;
	logic [3:0]  bad_r;
	logic [31:0] bit_cnt_r;
	logic [10:0] err_cnt_r;
	wire  [31:0] rx_eff   = cur_inv_r ? ~rx_word : rx_word;
	wire  [63:0] chk_pred = lfsr_adv32(chk_lfsr_r, cur_sel_r);
	wire  [31:0] diff     = rx_eff ^ chk_pred[31:0];
	wire  [5:0]  nerr     = ones32(diff);
	wire  [11:0] err_sum  = {1'b0, err_cnt_r} + {6'h00, nerr};
	wire         word_ok  = nerr == 6'h00;
	wire         word_bad = nerr > 6'h0F;
	wire         tracking = st_r == prbs_pkg::PRBS_TRACK;
	wire         count_on = chk_en && rx_valid && !chk_frz && tracking;
	// Auto mode tries sequence and polarity in turn: sel in low bits
	wire  [3:0]  auto_idx = {cur_inv_r, cur_sel_r} + 4'h1;

	always_ff @(posedge aclk) begin
		if (!aresetn || !chk_en) begin
			st_r       <= prbs_pkg::PRBS_SEED;
			chk_lfsr_r <= 64'h0000_0000_0000_0000;
			cur_sel_r  <= 3'h0;
			cur_inv_r  <= 1'b0;
			good_r     <= 4'h0;
			bad_r      <= 4'h0;
		end else if (rx_valid) begin
			case (st_r)
				prbs_pkg::PRBS_SEED: begin
					chk_lfsr_r <= {chk_lfsr_r[31:0], rx_eff};
					st_r       <= prbs_pkg::PRBS_HUNT;
					good_r     <= 4'h0;
				end
				prbs_pkg::PRBS_HUNT: begin
					chk_lfsr_r <= {chk_lfsr_r[31:0], rx_eff};
					if (word_ok && good_r == `PRBS_LOCK_GOOD) begin
						st_r <= prbs_pkg::PRBS_TRACK;
					end else if (word_ok) begin
						good_r <= good_r + 4'h1;
					end else if (chk_auto) begin
						{cur_inv_r, cur_sel_r} <= auto_idx;
						good_r <= 4'h0;
					end
					if (!chk_auto) begin
						cur_sel_r <= man_sel;
						cur_inv_r <= chk_inv;
					end
				end
				prbs_pkg::PRBS_TRACK: begin
					// Predicted word keeps errors from reseeding
					chk_lfsr_r <= chk_pred;
					if (word_bad && bad_r == `PRBS_SLIP_LIMIT)
						st_r <= prbs_pkg::PRBS_SEED;
					bad_r <= word_bad ? bad_r + 4'h1 : 4'h0;
				end
				default: st_r <= prbs_pkg::PRBS_SEED;
			endcase
		end
	end

	// Counters hold while frozen and resume from held values
	always_ff @(posedge aclk) begin
		if (!aresetn || cnt_clr) begin
			bit_cnt_r <= 32'h0000_0000;
			err_cnt_r <= 11'h000;
		end else if (count_on) begin
			bit_cnt_r <= bit_cnt_r + BIT_W[31:0];
			err_cnt_r <= err_sum[11] ? `PRBS_ERR_MAX : err_sum[10:0];
		end
	end

	// Interrupt events: error seen, lock gained, lock lost
	logic track_d_r;
	wire [2:0] irq_ev;
	assign irq_ev[`PRBS_IRQ_ERR_BIT]  = count_on && !word_ok;
	assign irq_ev[`PRBS_IRQ_LOCK_BIT] = tracking && !track_d_r;
	assign irq_ev[`PRBS_IRQ_LOSS_BIT] = !tracking && track_d_r;
	wire [2:0] irq_clr = (wr_iclr && lane0_r) ? wd[2:0] : 3'h0;
	// Sticky status: a new event wins over a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 3'h0;
			track_d_r  <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			track_d_r  <= tracking;
		end
	end
	assign irq = |(irq_stat_r & irq_en_r);

	// Read decode
	wire [7:0] ra = s_axi_araddr;
	wire [31:0] chk_stat = {24'h000000, 1'b0, cur_sel_r, 2'h0,
		cur_inv_r, tracking};
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0000_0000;
		case (ra)
			`PRBS_OFS_GEN_CTRL:  rd_mux = {24'h000000, gen_ctrl_r};
			`PRBS_OFS_USER_WORD: rd_mux = {16'h0000, user_word_r};
			`PRBS_OFS_CHK_CTRL:  rd_mux = {25'h0000000, chk_ctrl_r[6:0]};
			`PRBS_OFS_CHK_STAT:  rd_mux = chk_stat;
			`PRBS_OFS_BIT_CNT:   rd_mux = bit_cnt_r;
			`PRBS_OFS_ERR_CNT:   rd_mux = {21'h000000, err_cnt_r};
			`PRBS_OFS_TAP_PRE:   rd_mux = {25'h0000000, tap_pre_r};
			`PRBS_OFS_TAP_MAIN:  rd_mux = {25'h0000000, tap_main_r};
			`PRBS_OFS_TAP_POST:  rd_mux = {25'h0000000, tap_post_r};
			`PRBS_OFS_IRQ_STAT:  rd_mux = {29'h00000000, irq_stat_r};
			`PRBS_OFS_IRQ_EN:    rd_mux = {29'h00000000, irq_en_r};
			`PRBS_OFS_IRQ_CLR:   rd_mux = 32'h0000_0000;
			default:             rd_ok  = 1'b0;
		endcase
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `PRBS_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_ok ? `PRBS_RESP_OKAY : `PRBS_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule

// ### verification/prbs_lane_monitor.sv
// Bus and tap checks on the PRBS lane ports
module prbs_lane_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [6:0]  tap_pre,
	input wire logic [6:0]  tap_main,
	input wire logic [6:0]  tap_post
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Responses stand until taken
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=>
			s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	// Answer timing fixed by the hand-over
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> ##1 s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after)
		else $error("write response late");
	property p_r_after;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_after: assert property (p_r_after)
		else $error("read data late");
	property p_ar_ready;
		s_axi_arready == !s_axi_rvalid;
	endproperty
	a_ar_ready: assert property (p_ar_ready)
		else $error("read address ready wrong");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block)
		else $error("write taken while response pending");
	property p_r_err;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
	endproperty
	a_r_err: assert property (p_r_err)
		else $error("refused read carries data");
	// Taps only move with a completed write
	property p_tap;
		$changed(tap_pre) || $changed(tap_main) || $changed(tap_post)
			|-> $rose(s_axi_bvalid);
	endproperty
	a_tap: assert property (p_tap)
		else $error("tap moved without a write");
endmodule

// ### verification/prbs_partner.sv
// Link partner model: loops words back with commanded faults
module prbs_partner (
	input  wire logic        aclk,
	input  wire logic [31:0] tx_word,
	input  wire logic        tx_valid,
	input  wire logic        inv,
	input  wire logic [31:0] err_mask,
	output logic      [31:0] rx_word,
	output logic             rx_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rx_word = 32'h0;
	// Idle line toggles so stale data never looks good
	always @(posedge aclk) begin
		rx_valid <= tx_valid;
		rx_word  <= tx_valid ? tx_word ^ err_mask ^ {32{inv}} : ~rx_word;
	end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the PRBS lane
`include "prbs_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, inv, s_axi_awready;
	logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        tx_valid, rx_valid, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_wdata, s_axi_rdata, tx_word, rx_word, err_mask, v, b1;
	logic [6:0]  tap_pre, tap_main, tap_post;
	int          num_errors, compares, cyc, n, k, i;
	prbs_lane prbs_lane_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_word, .tx_valid,
		.rx_word, .rx_valid, .tap_pre, .tap_main, .tap_post, .irq);
	prbs_partner prbs_partner_i (.aclk, .tx_word, .tx_valid, .inv,
		.err_mask, .rx_word, .rx_valid);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic wrap_up();
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Four-state compare, counted
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// Write; ready for the response comes late on purpose
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n == 3) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
		// A write that never answers is a failure, not a skip
		if (!(s_axi_bvalid && s_axi_bready)) begin
			num_errors++;
			$display("wrong value at %0t: no write response", $time);
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n == 2) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
		if (!(s_axi_rvalid && s_axi_rready)) begin
			num_errors++;
			$display("wrong value at %0t: no read response", $time);
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		chk(v, e);
	endtask
	// Bounded wait for checker lock
	task automatic poll();
		k = 0;
		do begin
			rd(`PRBS_OFS_CHK_STAT, v);
			k++;
		end while (!v[0] && k < 60);
	endtask
	// Hang guard, far above the expected run length
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, inv} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		err_mask = 32'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset value, unmapped place refused
		rc(`PRBS_OFS_GEN_CTRL, 32'h0);
		rc(8'h40, 32'h0);
		chk(r, `PRBS_RESP_SLVERR);
		wr(8'h40, 32'h1);
		chk(r, `PRBS_RESP_SLVERR);
		// User word, plain then balanced
		wr(`PRBS_OFS_USER_WORD, 32'hA5C3);
		wr(`PRBS_OFS_GEN_CTRL, 32'h1);
		repeat (2) @(posedge aclk);
		chk(tx_valid, 1'b1);
		chk(tx_word, 32'hA5C3A5C3);
		wr(`PRBS_OFS_GEN_CTRL, 32'h5);
		repeat (2) @(posedge aclk);
		chk(tx_word, 32'hA5C35A3C);
		// Every order, auto detection, both polarities
		for (i = 0; i < 8; i++) begin
			inv <= i[0];
			wr(`PRBS_OFS_CHK_CTRL, 32'h0);
			wr(`PRBS_OFS_GEN_CTRL, {25'h0, i[2:0], 4'h3});
			wr(`PRBS_OFS_CHK_CTRL, 32'h3);
			poll();
			chk({v[6:4], v[1:0]}, {i[2:0], i[0], 1'b1});
			if (i < 2) begin
				v = tx_word;
				repeat ((1 << (7 + 2 * i)) - 1) @(posedge aclk);
				chk(tx_word, v);
			end
		end
		// Manual order 63 inverted, then counters
		wr(`PRBS_OFS_CHK_CTRL, 32'h0);
		wr(`PRBS_OFS_CHK_CTRL, 32'h75);
		poll();
		chk(v[0], 1'b1);
		wr(`PRBS_OFS_CHK_CTRL, 32'hF5);
		@(posedge aclk) err_mask <= 32'h7;
		@(posedge aclk) err_mask <= 32'h0;
		repeat (4) @(posedge aclk);
		wr(`PRBS_OFS_CHK_CTRL, 32'h7D);
		rc(`PRBS_OFS_ERR_CNT, 32'h3);
		rd(`PRBS_OFS_BIT_CNT, b1);
		chk(b1 != 0 && b1[4:0] == 5'h0, 1'b1);
		repeat (20) @(posedge aclk);
		rc(`PRBS_OFS_BIT_CNT, b1);
		wr(`PRBS_OFS_CHK_CTRL, 32'h75);
		repeat (20) @(posedge aclk);
		wr(`PRBS_OFS_CHK_CTRL, 32'h7D);
		rd(`PRBS_OFS_BIT_CNT, v);
		chk(v > b1, 1'b1);
		rc(`PRBS_OFS_ERR_CNT, 32'h3);
		// Masked error event, saturation, then enable and clear
		wr(`PRBS_OFS_IRQ_CLR, 32'h7);
		wr(`PRBS_OFS_IRQ_EN, 32'h0);
		wr(`PRBS_OFS_CHK_CTRL, 32'h75);
		err_mask <= 32'h7FFF;
		repeat (140) @(posedge aclk);
		chk(irq, 1'b0);
		err_mask <= 32'h0;
		wr(`PRBS_OFS_CHK_CTRL, 32'h7D);
		rc(`PRBS_OFS_ERR_CNT, 32'h7FF);
		rd(`PRBS_OFS_IRQ_STAT, v);
		chk(v[0], 1'b1);
		wr(`PRBS_OFS_IRQ_EN, 32'h1);
		@(posedge aclk);
		chk(irq, 1'b1);
		wr(`PRBS_OFS_IRQ_CLR, 32'h1);
		@(posedge aclk);
		chk(irq, 1'b0);
		// Read back all three taps, write signs flipped
		wr(`PRBS_OFS_TAP_PRE, 32'h41);
		wr(`PRBS_OFS_TAP_MAIN, 32'h12);
		wr(`PRBS_OFS_TAP_POST, 32'h0);
		for (i = 0; i < 3; i++) begin
			rd(`PRBS_OFS_TAP_PRE + 8'(4 * i), v);
			wr(`PRBS_OFS_TAP_PRE + 8'(4 * i), v ^ 32'h40);
		end
		@(posedge aclk);
		chk({tap_pre, tap_main, tap_post}, {7'h01, 7'h52, 7'h40});
		wrap_up();
	end
endmodule
bind prbs_lane prbs_lane_monitor prbs_lane_monitor_i (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .tap_pre, .tap_main, .tap_post);
